// ==== shared/ufc_defines.vh ====
// register indices, field positions, codes and reset values of the serial port configuration block
// assumes it is included by bare name; definitions only
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// register indices, byte address is four times the index
`define UFC_IDX_RXDATA_LO 6'h00
`define UFC_IDX_RXDATA_HI 6'h01
`define UFC_IDX_TXDATA_LO 6'h02
`define UFC_IDX_TXDATA_HI 6'h03
`define UFC_IDX_RX_CTRL 6'h06
`define UFC_IDX_FRAME 6'h07
`define UFC_IDX_BAUD_LO 6'h08
`define UFC_IDX_BAUD_HI 6'h09
`define UFC_IDX_DEBUG 6'h0B
`define UFC_IDX_EVENT 6'h0C

// reset values
`define UFC_RST_FRAME 8'h03
`define UFC_RST_SPI_FIELDS 2'h0
`define UFC_RST_BAUD 16'h0000
`define UFC_RST_RX_CTRL 3'h0
`define UFC_RST_DEBUG 1'h0
`define UFC_RST_EVENT 1'h0

// field positions
`define UFC_COMM_MODE_SELECT_MSB 7
`define UFC_COMM_MODE_SELECT_LSB 6
`define UFC_PARITY_SELECT_MSB 5
`define UFC_PARITY_SELECT_LSB 4
`define UFC_STOP_BIT_SELECT_POS 3
`define UFC_CHAR_SIZE_SELECT_MSB 2
`define UFC_CHAR_SIZE_SELECT_LSB 0
`define UFC_ORDER_POS 2
`define UFC_PHASE_POS 1
`define UFC_MULTIPROCESSOR_ADDR_MODE_POS 0
`define UFC_RECEIVER_SPEED_MODE_MSB 2
`define UFC_RECEIVER_SPEED_MODE_LSB 1
`define UFC_RUN_IN_DEBUG_HALT_POS 0
`define UFC_INFRARED_EVENT_INPUT_ENABLE_POS 0

// communication modes
`define UFC_CM_ASYNC 2'h0
`define UFC_CM_SYNC 2'h1
`define UFC_CM_IR 2'h2
`define UFC_CM_SPI 2'h3

// parity codes
`define UFC_PAR_OFF 2'h0
`define UFC_PAR_RSV 2'h1
`define UFC_PAR_EVEN 2'h2
`define UFC_PAR_ODD 2'h3

// character size codes
`define UFC_CH_5 3'h0
`define UFC_CH_6 3'h1
`define UFC_CH_7 3'h2
`define UFC_CH_8 3'h3
`define UFC_CH_RSV4 3'h4
`define UFC_CH_RSV5 3'h5
`define UFC_CH_9LOW 3'h6
`define UFC_CH_9HIGH 3'h7

`endif

// ==== sim/ufc_link_model.sv ====
// far-side shifter model: drains the transmit stream, offers receive words
// assumes same clock as the port; words offered count up from 0x1A5
`timescale 1ns/1ps
module ufc_link_model (
  // clock
  input wire i_clk,
  // bench control
  input wire i_stall,
  input wire i_offer,
  // transmit stream
  input wire i_tx_valid,
  input wire [8:0] i_tx_data,
  output reg o_tx_ready,
  // receive stream
  output reg o_rx_valid,
  output reg [8:0] o_rx_data,
  input wire i_rx_ready
);
  logic [8:0] got_q[$];
  logic [8:0] word;
  logic take;
  logic keep;
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 9'h000;
    word = 9'h1A5;
  end
  always @(posedge i_clk) begin
    take = o_rx_valid && i_rx_ready;
    keep = i_offer || (o_rx_valid && !i_rx_ready);
    if (i_tx_valid && o_tx_ready)
      got_q.push_back(i_tx_data);
    o_tx_ready <= !i_stall;
    if (take)
      word <= word + 9'h001;
    o_rx_valid <= keep;
    // an idle data line inverts its previous value every cycle
    o_rx_data <= keep ? (take ? word + 9'h001 : word) : ~o_rx_data;
  end
endmodule // ufc_link_model

// ==== sim/ufc_top_chk.sv ====
// concurrent checks on the serial port configuration block ports
// assumes bind onto ufc_top; one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "ufc_defines.vh"
module ufc_top_chk #(
  parameter DIV_WIDTH = 16
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire o_pready,
  // debug and event
  input wire i_debug_halt,
  input wire i_ir_event,
  input wire o_ir_event,
  input wire o_port_freeze,
  // configuration
  input wire [1:0] o_comm_mode,
  input wire o_parity_enable,
  input wire o_stop_bits_two,
  input wire [3:0] o_data_bits,
  input wire o_nine_bit_high_first,
  input wire o_bit_order_lsb,
  input wire o_sample_trailing,
  input wire [DIV_WIDTH-1:0] o_baud_divisor,
  input wire o_baud_tick,
  input wire o_xfer_disrupt,
  input wire o_tx_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_baud_wr;
    i_psel && i_penable && i_pwrite && o_pready && i_paddr[1:0] == 2'h0 &&
      (i_paddr[7:2] == `UFC_IDX_BAUD_LO || i_paddr[7:2] == `UFC_IDX_BAUD_HI);
  endsequence
  sequence s_tick_live;
    o_baud_tick && o_baud_divisor != 0 && !o_xfer_disrupt;
  endsequence
  sequence s_quiet;
    !o_xfer_disrupt && !o_port_freeze && $stable(o_baud_divisor);
  endsequence

  chk_baud_reload: assert property (s_baud_wr |=> o_xfer_disrupt)
    else $error("divisor write without prescaler reload");
  chk_tick_gap: assert property (s_tick_live ##1 s_quiet |-> !o_baud_tick)
    else $error("baud tick closer than divisor allows");
  chk_freeze_tick: assert property (o_port_freeze && $past(o_port_freeze) |-> !o_baud_tick)
    else $error("baud tick while frozen");
  chk_freeze_gate: assert property (o_port_freeze |-> i_debug_halt && !o_tx_valid && !o_ir_event)
    else $error("port active while frozen");
  chk_event_pass: assert property (o_ir_event |-> i_ir_event && o_comm_mode == `UFC_CM_IR)
    else $error("event passed outside infrared mode");
  chk_spi_only: assert property (o_comm_mode != `UFC_CM_SPI |-> !o_bit_order_lsb && !o_sample_trailing)
    else $error("spi controls active outside spi mode");
  chk_spi_frame: assert property (o_comm_mode == `UFC_CM_SPI && $past(o_comm_mode) == `UFC_CM_SPI
    |-> !o_parity_enable && !o_stop_bits_two)
    else $error("frame fields active in spi mode");
  chk_size_range: assert property (o_data_bits >= 4'h5 && o_data_bits <= 4'h9)
    else $error("data bits outside 5 to 9");
  chk_high_first: assert property (o_nine_bit_high_first |-> o_data_bits == 4'h9)
    else $error("high byte first without nine bits");
endmodule // ufc_top_chk

bind ufc_top ufc_top_chk #(.DIV_WIDTH(DIV_WIDTH)) u_chk (.*);

// ==== sim/usart_frame_and_baud_config_tb.sv ====
// self-checking bench: apb register tasks, link model on the data streams
// assumes ufc_top with the bound checker; 25 MHz clock
`timescale 1ns/1ps
`include "ufc_defines.vh"
module usart_frame_and_baud_config_tb;
  reg i_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg i_psel = 1'b0;
  reg i_penable = 1'b0;
  reg i_pwrite = 1'b0;
  reg [7:0] i_paddr = 8'h00;
  reg [31:0] i_pwdata = 32'h0;
  reg i_debug_halt = 1'b0;
  reg i_ir_event = 1'b0;
  reg stall = 1'b0;
  reg offer = 1'b0;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_ir_event, o_port_freeze, o_multiprocessor_addr_mode, o_parity_enable;
  wire o_parity_odd, o_stop_bits_two, o_nine_bit_high_first, o_bit_order_lsb, o_sample_trailing;
  wire o_baud_tick, o_xfer_disrupt, o_tx_valid, i_tx_ready, i_rx_valid, o_rx_ready;
  wire [1:0] o_comm_mode, o_receiver_speed_mode;
  wire [3:0] o_data_bits;
  wire [15:0] o_baud_divisor;
  wire [8:0] o_tx_data, i_rx_data;
  integer err_total = 0, tests_run = 0, n_dis = 0, n, i;
  reg [31:0] rdv;
  reg erv;

  ufc_top DUT (.*);
  ufc_link_model u_link (.i_clk(i_clk), .i_stall(stall), .i_offer(offer), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .i_rx_ready(o_rx_ready));

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_xfer_disrupt === 1'b1) n_dis <= n_dis + 1;

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input wr, input [5:0] idx, input [31:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'h0};
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // pready, read data and error are taken at the rising edge that completes the access
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rdv = o_prdata;
    erv = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rd(input string nm, input [5:0] idx, input [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rdv, exp);
  endtask
  task settle;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #800000;
    err_total = err_total + 1;
    end_sim;
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    offer <= 1'b1;
    rd("frame reset", `UFC_IDX_FRAME, 32'h03);
    rd("baud reset", `UFC_IDX_BAUD_HI, 32'h0);
    rd("debug reset", `UFC_IDX_DEBUG, 32'h0);
    rd("event reset", `UFC_IDX_EVENT, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, `UFC_IDX_FRAME, {2'h0, i[1:0], i[0], i[2:0]});
      rd("frame back", `UFC_IDX_FRAME, {2'h0, i[1:0], i[0], i[2:0]});
      chk("data bits", o_data_bits, (i < 4) ? i + 5 : (i == 4 ? 8 : 9));
      chk("high first", o_nine_bit_high_first, i == 7);
      chk("parity on", o_parity_enable, i[1]);
      chk("parity odd", o_parity_odd, i[1:0] == 3);
      chk("stop two", o_stop_bits_two, i[0]);
    end
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, `UFC_IDX_FRAME, {i[1:0], 6'h03});
      @(posedge i_clk);
      chk("mode out", o_comm_mode, i);
    end
    i_ir_event <= 1'b1;
    settle;
    chk("event pass", o_ir_event, 1);
    apb(1'b1, `UFC_IDX_EVENT, 32'h1);
    settle;
    chk("event blocked", o_ir_event, 0);
    apb(1'b1, `UFC_IDX_EVENT, 32'h0);
    i_debug_halt <= 1'b1;
    settle;
    chk("freeze on", o_port_freeze, 1);
    chk("event frozen", o_ir_event, 0);
    apb(1'b1, `UFC_IDX_DEBUG, 32'h1);
    settle;
    chk("debug run", o_ir_event, 1);
    $display("test modes done");
    apb(1'b1, `UFC_IDX_FRAME, 32'h23);
    // the write entering host spi mode still sets the normal fields, here to 0x23 again; the next write sets the spi fields
    apb(1'b1, `UFC_IDX_FRAME, 32'hE3);
    apb(1'b1, `UFC_IDX_FRAME, 32'hC4);
    rd("spi view", `UFC_IDX_FRAME, 32'hC4);
    chk("lsb first", o_bit_order_lsb, 1);
    chk("parity hidden", o_parity_enable, 0);
    n = n_dis;
    apb(1'b1, `UFC_IDX_FRAME, 32'hC2);
    settle;
    chk("order disrupt", n_dis - n, 1);
    chk("trailing", o_sample_trailing, 1);
    apb(1'b1, `UFC_IDX_FRAME, 32'h00);
    rd("normal kept", `UFC_IDX_FRAME, 32'h23);
    chk("leading", o_sample_trailing, 0);
    $display("test spi done");
    n = n_dis;
    apb(1'b1, `UFC_IDX_BAUD_LO, 32'h03);
    apb(1'b1, `UFC_IDX_BAUD_HI, 32'h01);
    settle;
    chk("divisor", o_baud_divisor, 16'h0103);
    chk("reloads", n_dis - n, 2);
    rd("baud low", `UFC_IDX_BAUD_LO, 32'h03);
    apb(1'b1, `UFC_IDX_BAUD_HI, 32'h00);
    // let the reload land so a tick of the old count is not taken as the first
    settle;
    do @(negedge i_clk); while (o_baud_tick !== 1'b1);
    n = 0;
    do begin
      @(negedge i_clk);
      n = n + 1;
    end while (o_baud_tick !== 1'b1);
    chk("tick gap", n, 4);
    apb(1'b1, `UFC_IDX_RX_CTRL, 32'h1);
    settle;
    chk("multiproc", o_multiprocessor_addr_mode, 1);
    chk("speed normal", o_receiver_speed_mode, 0);
    rd("rx first", `UFC_IDX_RXDATA_LO, 32'hA5);
    rd("rx second", `UFC_IDX_RXDATA_LO, 32'hA6);
    apb(1'b1, 6'h3F, 32'hFF);
    chk("write refused", erv, 1);
    rd("unmapped", 6'h3F, 32'h0);
    $display("test baud and rx done");
    // halt is still asserted: clearing debug-run freezes the port again
    apb(1'b1, `UFC_IDX_DEBUG, 32'h0);
    stall <= 1'b1;
    apb(1'b1, `UFC_IDX_TXDATA_LO, 32'h11);
    apb(1'b1, `UFC_IDX_TXDATA_LO, 32'h22);
    settle;
    chk("tx frozen", o_tx_valid, 0);
    @(posedge i_clk);
    i_debug_halt <= 1'b0;
    fork
      apb(1'b1, `UFC_IDX_TXDATA_LO, 32'h33);
      begin
        repeat (6) @(negedge i_clk);
        chk("push held", o_pready, 0);
        @(posedge i_clk);
        stall <= 1'b0;
      end
    join
    apb(1'b1, `UFC_IDX_FRAME, 32'h06);
    apb(1'b1, `UFC_IDX_TXDATA_LO, 32'h5A);
    apb(1'b1, `UFC_IDX_TXDATA_HI, 32'h01);
    apb(1'b1, `UFC_IDX_FRAME, 32'h07);
    apb(1'b1, `UFC_IDX_TXDATA_HI, 32'h01);
    apb(1'b1, `UFC_IDX_TXDATA_LO, 32'hC3);
    repeat (8) @(posedge i_clk);
    chk("tx words", u_link.got_q.size(), 5);
    chk("tx order", {u_link.got_q[0][7:0], u_link.got_q[1][7:0], u_link.got_q[2][7:0]}, 24'h112233);
    chk("nine low first", u_link.got_q[3], 9'h15A);
    chk("nine high first", u_link.got_q[4], 9'h1C3);
    $display("test tx done");
    end_sim;
  end
endmodule // usart_frame_and_baud_config_tb

// ==== verilog/ufc_baud_gen.v ====
// baud prescaler: one-cycle tick every divisor+1 enabled cycles
// assumes reload pulse arrives after the divisor input already holds the new value
`timescale 1ns/1ps
module ufc_baud_gen #(
  parameter DIV_WIDTH = 16
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // control
  input wire [DIV_WIDTH-1:0] i_divisor,
  input wire i_reload,
  input wire i_enable,
  // tick out
  output wire o_tick
);
  reg [DIV_WIDTH-1:0] count_ff;
  reg tick_ff;

  assign o_tick = tick_ff;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_ff <= {DIV_WIDTH{1'b0}};
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (i_reload) begin
        // restart at once, mid-frame or not
        count_ff <= i_divisor;
      end else if (i_enable) begin
        if (count_ff == {DIV_WIDTH{1'b0}}) begin
          count_ff <= i_divisor;
          tick_ff <= 1'b1;
        end else begin
          count_ff <= count_ff - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // ufc_baud_gen

// ==== verilog/ufc_buf2.v ====
// two-entry valid/ready buffer
// assumes both sides on i_clk; in_ready is honest full, out_valid honest empty
`timescale 1ns/1ps
module ufc_buf2 #(
  parameter WIDTH = 9
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // filling side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // draining side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg rd_ptr_ff;
  reg wr_ptr_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  assign o_in_ready = (count_ff != 2'h2);
  assign o_out_valid = (count_ff != 2'h0);
  assign o_out_data = mem_ff[rd_ptr_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      mem_ff[0] <= {WIDTH{1'b0}};
      mem_ff[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= i_in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule // ufc_buf2

// ==== verilog/ufc_top.v ====
// serial port frame, mode and baud configuration with apb register access
// assumes apb master on i_clk; tx/rx datapath, debug halt and event source on the same clock
// Operation
// - a control bit enables receiver multi-processor addressing mode.
// - two-bit mode field selects asynchronous, synchronous, infrared or host spi.
// - in host spi mode frame control shows only mode, bit order, phase.
// - parity field: none, reserved, even, odd.
// - transmitter sends one or two stop bits; receiver ignores the setting.
// - shared size field selects 5 to 9 data bits; two codes reserved.
// - nine-bit codes choose low or high byte first for data access.
// - spi bit order selects msb or lsb first; a change disrupts transfers.
// - spi phase selects sampling on leading or trailing clock edge.
// - 16-bit baud divisor split across two byte registers.
// - any divisor write reloads the prescaler at once.
// - without debug-run the port freezes and ignores events during halt.
// - infrared event input enabled by 0, disabled by 1.
`timescale 1ns/1ps
`include "ufc_defines.vh"
module ufc_top #(
  parameter DIV_WIDTH = 16,
  parameter DATA_WIDTH = 9
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // debug and event
  input wire i_debug_halt,
  input wire i_ir_event,
  output wire o_ir_event,
  output wire o_port_freeze,
  // effective configuration
  output wire [1:0] o_comm_mode,
  output wire o_multiprocessor_addr_mode,
  output wire [1:0] o_receiver_speed_mode,
  output wire o_parity_enable,
  output wire o_parity_odd,
  output wire o_stop_bits_two,
  output wire [3:0] o_data_bits,
  output wire o_nine_bit_high_first,
  output wire o_bit_order_lsb,
  output wire o_sample_trailing,
  output wire [DIV_WIDTH-1:0] o_baud_divisor,
  output wire o_baud_tick,
  output wire o_xfer_disrupt,
  // transmit data towards the shifter
  output wire o_tx_valid,
  output wire [DATA_WIDTH-1:0] o_tx_data,
  input wire i_tx_ready,
  // receive data from the shifter
  input wire i_rx_valid,
  input wire [DATA_WIDTH-1:0] i_rx_data,
  output wire o_rx_ready
);
  // stored registers
  reg [7:0] frame_ff;
  reg [1:0] spi_fields_ff;
  reg [DIV_WIDTH-1:0] baud_ff;
  reg [2:0] rx_ctrl_ff;
  reg run_in_debug_halt_ff;
  reg infrared_event_input_enable_ff;
  reg [7:0] tx_lo_ff;
  reg tx_hi_ff;
  reg [31:0] prdata_ff;
  reg baud_reload_ff;
  reg disrupt_ff;
  // registered effective configuration
  reg parity_enable_ff;
  reg parity_odd_ff;
  reg [3:0] data_bits_ff;
  reg nine_high_first_ff;
  reg nine_bit_ff;

  wire [5:0] idx;
  wire setup;
  wire access;
  wire wr_acc;
  wire rd_acc;
  wire mapped;
  wire [1:0] comm_mode_select;
  wire host_spi_mode;
  wire infrared_mode;
  wire freeze;
  wire is_push;
  wire is_pop;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [DATA_WIDTH-1:0] push_data;
  reg [31:0] nxt_prdata;
  reg [3:0] nxt_data_bits;
  reg nxt_nine_high_first;
  reg nxt_nine_bit;

  // size code to effective bit count, reserved codes to nearest defined
  function [3:0] ufc_size_bits;
    input [2:0] code;
    begin
      case (code)
        `UFC_CH_5: ufc_size_bits = 4'h5;
        `UFC_CH_6: ufc_size_bits = 4'h6;
        `UFC_CH_7: ufc_size_bits = 4'h7;
        `UFC_CH_8: ufc_size_bits = 4'h8;
        `UFC_CH_RSV4: ufc_size_bits = 4'h8;
        default: ufc_size_bits = 4'h9;
      endcase
    end
  endfunction

  function ufc_idx_hit;
    input [5:0] a;
    input [5:0] b;
    begin
      ufc_idx_hit = (a == b);
    end
  endfunction

  assign idx = i_paddr[7:2];
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign comm_mode_select = frame_ff[`UFC_COMM_MODE_SELECT_MSB:`UFC_COMM_MODE_SELECT_LSB];
  assign host_spi_mode = (comm_mode_select == `UFC_CM_SPI);
  assign infrared_mode = (comm_mode_select == `UFC_CM_IR);
  assign freeze = i_debug_halt & ~run_in_debug_halt_ff;

  assign mapped = ufc_idx_hit(idx, `UFC_IDX_RXDATA_LO) | ufc_idx_hit(idx, `UFC_IDX_RXDATA_HI) |
                  ufc_idx_hit(idx, `UFC_IDX_TXDATA_LO) | ufc_idx_hit(idx, `UFC_IDX_TXDATA_HI) |
                  ufc_idx_hit(idx, `UFC_IDX_RX_CTRL) | ufc_idx_hit(idx, `UFC_IDX_FRAME) |
                  ufc_idx_hit(idx, `UFC_IDX_BAUD_LO) | ufc_idx_hit(idx, `UFC_IDX_BAUD_HI) |
                  ufc_idx_hit(idx, `UFC_IDX_DEBUG) | ufc_idx_hit(idx, `UFC_IDX_EVENT) |
                  (i_paddr[1:0] != 2'h0);

  // the access that completes a nine-bit word is the second byte in the chosen order
  assign is_push = nine_bit_ff ?
                   ufc_idx_hit(idx, nine_high_first_ff ? `UFC_IDX_TXDATA_LO : `UFC_IDX_TXDATA_HI) :
                   ufc_idx_hit(idx, `UFC_IDX_TXDATA_LO);
  assign is_pop = nine_bit_ff ?
                  ufc_idx_hit(idx, nine_high_first_ff ? `UFC_IDX_RXDATA_LO : `UFC_IDX_RXDATA_HI) :
                  ufc_idx_hit(idx, `UFC_IDX_RXDATA_LO);

  // a full buffer stalls the completing write
  assign o_pready = ~(i_psel & i_pwrite & is_push & (i_paddr[1:0] == 2'h0)) | buf_in_ready;
  assign o_pslverr = access & o_pready & ~mapped;
  assign wr_acc = access & o_pready & i_pwrite & mapped & (i_paddr[1:0] == 2'h0);
  assign rd_acc = access & o_pready & ~i_pwrite & mapped & (i_paddr[1:0] == 2'h0);
  assign o_prdata = prdata_ff;

  assign push_data = !nine_bit_ff ? {1'b0, i_pwdata[7:0]} :
                     nine_high_first_ff ? {tx_hi_ff, i_pwdata[7:0]} : {i_pwdata[0], tx_lo_ff};
  assign o_rx_ready = rd_acc & is_pop;

  // read view, taken in the setup cycle
  always @* begin
    nxt_prdata = 32'h00000000;
    case (idx)
      `UFC_IDX_RXDATA_LO: nxt_prdata[7:0] = i_rx_data[7:0];
      `UFC_IDX_RXDATA_HI: nxt_prdata[0] = i_rx_data[8];
      `UFC_IDX_TXDATA_LO: nxt_prdata[7:0] = tx_lo_ff;
      `UFC_IDX_TXDATA_HI: nxt_prdata[0] = tx_hi_ff;
      `UFC_IDX_RX_CTRL: nxt_prdata[2:0] = rx_ctrl_ff;
      `UFC_IDX_FRAME: begin
        if (host_spi_mode) begin
          nxt_prdata[`UFC_COMM_MODE_SELECT_MSB:`UFC_COMM_MODE_SELECT_LSB] = comm_mode_select;
          nxt_prdata[`UFC_ORDER_POS:`UFC_PHASE_POS] = spi_fields_ff;
        end else begin
          nxt_prdata[7:0] = frame_ff;
        end
      end
      `UFC_IDX_BAUD_LO: nxt_prdata[7:0] = baud_ff[7:0];
      `UFC_IDX_BAUD_HI: nxt_prdata[7:0] = baud_ff[15:8];
      `UFC_IDX_DEBUG: nxt_prdata[`UFC_RUN_IN_DEBUG_HALT_POS] = run_in_debug_halt_ff;
      `UFC_IDX_EVENT: nxt_prdata[`UFC_INFRARED_EVENT_INPUT_ENABLE_POS] = infrared_event_input_enable_ff;
      default: nxt_prdata = 32'h00000000;
    endcase
    if (i_paddr[1:0] != 2'h0) begin
      nxt_prdata = 32'h00000000;
    end
  end

  // register writes
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_ff <= `UFC_RST_FRAME;
      spi_fields_ff <= `UFC_RST_SPI_FIELDS;
      baud_ff <= `UFC_RST_BAUD;
      rx_ctrl_ff <= `UFC_RST_RX_CTRL;
      run_in_debug_halt_ff <= `UFC_RST_DEBUG;
      infrared_event_input_enable_ff <= `UFC_RST_EVENT;
      tx_lo_ff <= 8'h00;
      tx_hi_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      baud_reload_ff <= 1'b0;
      disrupt_ff <= 1'b0;
    end else begin
      baud_reload_ff <= 1'b0;
      disrupt_ff <= 1'b0;
      if (setup && !i_pwrite) begin
        prdata_ff <= nxt_prdata;
      end
      if (wr_acc) begin
        case (idx)
          `UFC_IDX_TXDATA_LO: tx_lo_ff <= i_pwdata[7:0];
          `UFC_IDX_TXDATA_HI: tx_hi_ff <= i_pwdata[0];
          `UFC_IDX_RX_CTRL: rx_ctrl_ff <= i_pwdata[2:0];
          `UFC_IDX_FRAME: begin
            frame_ff[`UFC_COMM_MODE_SELECT_MSB:`UFC_COMM_MODE_SELECT_LSB] <= i_pwdata[`UFC_COMM_MODE_SELECT_MSB:`UFC_COMM_MODE_SELECT_LSB];
            if (host_spi_mode) begin
              spi_fields_ff <= i_pwdata[`UFC_ORDER_POS:`UFC_PHASE_POS];
              disrupt_ff <= (i_pwdata[`UFC_ORDER_POS] != spi_fields_ff[1]);
            end else begin
              frame_ff[5:0] <= i_pwdata[5:0];
            end
          end
          `UFC_IDX_BAUD_LO: begin
            baud_ff[7:0] <= i_pwdata[7:0];
            baud_reload_ff <= 1'b1;
            disrupt_ff <= 1'b1;
          end
          `UFC_IDX_BAUD_HI: begin
            baud_ff[15:8] <= i_pwdata[7:0];
            baud_reload_ff <= 1'b1;
            disrupt_ff <= 1'b1;
          end
          `UFC_IDX_DEBUG: run_in_debug_halt_ff <= i_pwdata[`UFC_RUN_IN_DEBUG_HALT_POS];
          `UFC_IDX_EVENT: infrared_event_input_enable_ff <= i_pwdata[`UFC_INFRARED_EVENT_INPUT_ENABLE_POS];
          default: tx_hi_ff <= tx_hi_ff;
        endcase
      end
    end
  end

  // effective framing decode
  always @* begin
    nxt_data_bits = ufc_size_bits(frame_ff[`UFC_CHAR_SIZE_SELECT_MSB:`UFC_CHAR_SIZE_SELECT_LSB]);
    nxt_nine_bit = (nxt_data_bits == 4'h9);
    nxt_nine_high_first = (frame_ff[`UFC_CHAR_SIZE_SELECT_MSB:`UFC_CHAR_SIZE_SELECT_LSB] == `UFC_CH_9HIGH);
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      parity_enable_ff <= 1'b0;
      parity_odd_ff <= 1'b0;
      data_bits_ff <= 4'h8;
      nine_high_first_ff <= 1'b0;
      nine_bit_ff <= 1'b0;
    end else begin
      // reserved parity code acts as parity off
      parity_enable_ff <= frame_ff[`UFC_PARITY_SELECT_MSB];
      parity_odd_ff <= (frame_ff[`UFC_PARITY_SELECT_MSB:`UFC_PARITY_SELECT_LSB] == `UFC_PAR_ODD);
      data_bits_ff <= nxt_data_bits;
      nine_bit_ff <= nxt_nine_bit;
      nine_high_first_ff <= nxt_nine_high_first;
    end
  end

  assign o_comm_mode = comm_mode_select;
  assign o_multiprocessor_addr_mode = rx_ctrl_ff[`UFC_MULTIPROCESSOR_ADDR_MODE_POS];
  // software is expected to keep this at normal in asynchronous and infrared modes
  assign o_receiver_speed_mode = rx_ctrl_ff[`UFC_RECEIVER_SPEED_MODE_MSB:`UFC_RECEIVER_SPEED_MODE_LSB];
  assign o_parity_enable = parity_enable_ff & ~host_spi_mode;
  assign o_parity_odd = parity_odd_ff;
  assign o_stop_bits_two = frame_ff[`UFC_STOP_BIT_SELECT_POS] & ~host_spi_mode;
  assign o_data_bits = data_bits_ff;
  assign o_nine_bit_high_first = nine_high_first_ff;
  assign o_bit_order_lsb = host_spi_mode & spi_fields_ff[1];
  assign o_sample_trailing = host_spi_mode & spi_fields_ff[0];
  assign o_baud_divisor = baud_ff;
  assign o_xfer_disrupt = disrupt_ff;
  assign o_port_freeze = freeze;
  assign o_ir_event = i_ir_event & infrared_mode & ~infrared_event_input_enable_ff & ~freeze;
  assign o_tx_valid = buf_out_valid & ~freeze;

  ufc_baud_gen #(
    .DIV_WIDTH(DIV_WIDTH)
  ) u_baud (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_divisor(baud_ff),
    .i_reload(baud_reload_ff),
    .i_enable(~freeze),
    .o_tick(o_baud_tick)
  );

  ufc_buf2 #(
    .WIDTH(DATA_WIDTH)
  ) u_txbuf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(access & i_pwrite & is_push & (i_paddr[1:0] == 2'h0)),
    .i_in_data(push_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(o_tx_data),
    .i_out_ready(i_tx_ready & ~freeze)
  );
endmodule // ufc_top
